/* rtl/swta_top.sv */
// Indirect access to static, reserved multicast and VLAN tables,
// plus the VLAN ingress lookup. Assumes an Avalon-MM master on the bus
// and a lookup engine that presents one request per cycle at most.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module swta_top #(
  parameter int HASH_W = 12
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic LKP_REQ,
  input wire logic [swta_pkg::VID_W-1:0] LKP_VID,
  input wire logic [swta_pkg::MAC_W-1:0] LKP_DA,
  output logic LKP_VALID,
  output logic LKP_ENTRY_VALID,
  output logic [2:0] LKP_PRIORITY,
  output logic [2:0] LKP_SPANNING_TREE_INSTANCE,
  output logic [swta_pkg::NPORT-1:0] LKP_FWD_MASK,
  output logic LKP_ALT_FWD,
  output logic [swta_pkg::NPORT-1:0] LKP_UNTAG_MASK,
  output logic [HASH_W-1:0] LKP_HASH_IDX,
  input wire logic [swta_pkg::STAT_AW-1:0] STAT_IDX,
  output logic STAT_VALID,
  output logic STAT_PORT_STATE_BYPASS,
  output logic STAT_MULTICAST_GROUP_MATCH_EN,
  output logic [swta_pkg::NPORT-1:0] STAT_FWD_MASK,
  output logic [swta_pkg::FGID_W-1:0] STAT_FILTER_GROUP_ID,
  output logic [swta_pkg::MAC_W-1:0] STAT_MAC
);
  import swta_pkg::*;

  typedef enum logic {ST_IDLE, ST_CAPT} swta_state_t;

  //////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge, then clear reserved bits
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be,
                                        input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r & m;
  endfunction

  // XOR fold of group id and address into the lookup index
  function automatic logic [HASH_W-1:0] fold(input logic [HIN_W-1:0] v);
    logic [HASH_W-1:0] h;
    h = '0;
    for (int i = 0; i < HIN_W; i++) begin
      h[i % HASH_W] = h[i % HASH_W] ^ v[i];
    end
    return h;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Register state

  logic [31:0] sent1_q, sent2_q, sent3_q, sent4_q; // Static data words
  logic [31:0] sent1_d, sent2_d, sent3_d, sent4_d;
  logic [31:0] vent0_q, vent1_q, vent2_q; // VLAN entry words
  logic [31:0] vent0_d, vent1_d, vent2_d;
  logic [31:0] vidx_q, vidx_d; // VLAN index
  logic [31:0] tctl_q, tctl_d; // Shared table control
  logic [31:0] vctl_q, vctl_d; // VLAN access control
  logic [31:0] lkctl_q, lkctl_d; // Lookup control, VLAN mode enable
  swta_state_t state_q, state_d; // Access sequencer
  logic kind_q; // Running access is VLAN
  logic act_q; // Running access action
  logic sel_q; // Running access table select
  logic rd_ack_q; // Read answered this cycle
  logic [31:0] rdata_q; // Read data register

  //////////////////////////////////////////////////////////////////////
  // Bus decode

  wire wr_sent1 = AVS_WRITE && AVS_ADDRESS == OFS_SENT1;
  wire wr_sent2 = AVS_WRITE && AVS_ADDRESS == OFS_SENT2;
  wire wr_sent3 = AVS_WRITE && AVS_ADDRESS == OFS_SENT3;
  wire wr_sent4 = AVS_WRITE && AVS_ADDRESS == OFS_SENT4;
  wire wr_vent0 = AVS_WRITE && AVS_ADDRESS == OFS_VENT0;
  wire wr_vent1 = AVS_WRITE && AVS_ADDRESS == OFS_VENT1;
  wire wr_vent2 = AVS_WRITE && AVS_ADDRESS == OFS_VENT2;
  wire wr_vidx = AVS_WRITE && AVS_ADDRESS == OFS_VIDX;
  wire wr_tctl = AVS_WRITE && AVS_ADDRESS == OFS_TCTL;
  wire wr_vctl = AVS_WRITE && AVS_ADDRESS == OFS_VCTL;
  wire wr_lkctl = AVS_WRITE && AVS_ADDRESS == OFS_LKCTL;
  wire rd_take = AVS_READ && !rd_ack_q; // First read cycle

  //////////////////////////////////////////////////////////////////////
  // Access sequencer decode

  wire tc_go = tctl_q[TC_GO_BIT];
  wire vc_go = vctl_q[VC_GO_BIT];
  wire idle = state_q == ST_IDLE;
  wire st_start = idle && tc_go; // Shared access takes priority
  wire vl_start = idle && !tc_go && vc_go;
  wire tc_sel = tctl_q[TC_SEL_BIT];
  wire tc_act = tctl_q[TC_ACT_BIT];
  wire capt = state_q == ST_CAPT;
  wire done_tc = capt && !kind_q;
  wire done_vl = capt && kind_q;
  wire cap_rd = capt && act_q == ACT_READ;
  wire cap_st = cap_rd && !kind_q && sel_q == SEL_STATIC;
  wire cap_mc = cap_rd && !kind_q && sel_q == SEL_MCAST;
  wire cap_vl = cap_rd && kind_q;
  // Table write strobes at start of the access
  wire st_we = st_start && tc_act == ACT_WRITE && tc_sel == SEL_STATIC;
  wire mc_we = st_start && tc_act == ACT_WRITE && tc_sel == SEL_MCAST;
  wire vl_we = vl_start && vctl_q[VC_ACT_BIT] == ACT_WRITE;
  wire lk_en = lkctl_q[LK_EN_BIT];

  logic [STAT_W-1:0] st_rd_a, st_rd_b; // Static table read words
  logic [VENT_W-1:0] vl_rd_a, vl_rd_b; // VLAN table read words
  logic [NPORT-1:0] mc_rmask; // Multicast group mask read

  // Packed table words built from the data registers
  wire [STAT_W-1:0] st_wword = {sent1_q, sent2_q, sent3_q, sent4_q};
  wire [VENT_W-1:0] vl_wword = {vent2_q[NPORT-1:0], vent1_q[NPORT-1:0],
                                vent0_q[14:0]};

  //////////////////////////////////////////////////////////////////////
  // Next values of the data registers; a table read wins over the bus

  assign sent1_d = cap_st ? st_rd_a[127:96] :
                   wr_sent1 ? merge(sent1_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                    SENT1_MASK) : sent1_q;
  // Bypass, group match and port mask bits live in word2
  assign sent2_d = cap_st ? st_rd_a[95:64] :
                   cap_mc ? {sent2_q[31:NPORT], mc_rmask} :
                   wr_sent2 ? merge(sent2_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                    SENT2_MASK) : sent2_q;
  assign sent3_d = cap_st ? st_rd_a[63:32] :
                   wr_sent3 ? merge(sent3_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                    SENT3_MASK) : sent3_q;
  assign sent4_d = cap_st ? st_rd_a[31:0] :
                   wr_sent4 ? merge(sent4_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                    SENT4_MASK) : sent4_q;
  // VLAN entry words take the read result
  assign vent0_d = cap_vl ? {17'h0, vl_rd_a[14:0]} :
                   wr_vent0 ? merge(vent0_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                    VENT0_MASK) : vent0_q;
  assign vent1_d = cap_vl ? {25'h0, vl_rd_a[21:15]} :
                   wr_vent1 ? merge(vent1_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                    PMASK_MASK) : vent1_q;
  assign vent2_d = cap_vl ? {25'h0, vl_rd_a[28:22]} :
                   wr_vent2 ? merge(vent2_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                    PMASK_MASK) : vent2_q;
  assign vidx_d = wr_vidx ? merge(vidx_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                  VIDX_MASK) : vidx_q;
  assign lkctl_d = wr_lkctl ? merge(lkctl_q, AVS_WRITEDATA, AVS_BYTEENABLE,
                                    LKCTL_MASK) : lkctl_q;
  // Control writes ignored while go is set; done clears go
  assign tctl_d = done_tc ? tctl_q & ~(32'h1 << TC_GO_BIT) :
                  (wr_tctl && !tc_go) ?
                  merge(tctl_q, AVS_WRITEDATA, AVS_BYTEENABLE, TCTL_MASK) :
                  tctl_q;
  assign vctl_d = done_vl ? vctl_q & ~(32'h1 << VC_GO_BIT) :
                  (wr_vctl && !vc_go) ?
                  merge(vctl_q, AVS_WRITEDATA, AVS_BYTEENABLE, VCTL_MASK) :
                  vctl_q;

  // Data and control registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sent1_q <= RST_WORD;
      sent2_q <= RST_WORD;
      sent3_q <= RST_WORD;
      sent4_q <= RST_WORD;
      vent0_q <= RST_WORD;
      vent1_q <= RST_WORD;
      vent2_q <= RST_WORD;
      vidx_q <= RST_WORD;
      tctl_q <= RST_WORD;
      vctl_q <= RST_WORD;
      lkctl_q <= RST_WORD;
    end else begin
      sent1_q <= sent1_d;
      sent2_q <= sent2_d;
      sent3_q <= sent3_d;
      sent4_q <= sent4_d;
      vent0_q <= vent0_d;
      vent1_q <= vent1_d;
      vent2_q <= vent2_d;
      vidx_q <= vidx_d;
      tctl_q <= tctl_d;
      vctl_q <= vctl_d;
      lkctl_q <= lkctl_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Access sequencer: start in idle, capture and finish one cycle later

  always_comb begin
    case (state_q)
      ST_IDLE: state_d = (st_start || vl_start) ? ST_CAPT : ST_IDLE;
      ST_CAPT: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Remember which access runs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_q <= ST_IDLE;
      kind_q <= 1'b0;
      act_q <= ACT_WRITE;
      sel_q <= SEL_STATIC;
    end else begin
      state_q <= state_d;
      if (idle) begin
        kind_q <= !tc_go;
        act_q <= tc_go ? tc_act : vctl_q[VC_ACT_BIT];
        sel_q <= tc_sel;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Tables

  // Static table, 16 entries on a 4-bit index
  swta_ram #(.W(STAT_W), .AW(STAT_AW)) u_stat (
    .clk(CLK),
    .rst(SYS_RST),
    .we(st_we),
    .waddr(tctl_q[STAT_AW-1:0]),
    .wdata(st_wword),
    .raddr_a(tctl_q[STAT_AW-1:0]),
    .rdata_a(st_rd_a),
    .raddr_b(STAT_IDX),
    .rdata_b(st_rd_b)
  );

  // Reserved multicast groups, 6-bit index
  swta_mcast u_mcast (
    .clk(CLK),
    .rst(SYS_RST),
    .we(mc_we),
    .idx(tctl_q[MC_IDX_W-1:0]),
    .wmask(sent2_q[NPORT-1:0]),
    .rmask_q(mc_rmask)
  );

  // VLAN table, one entry per VID
  swta_ram #(.W(VENT_W), .AW(VID_W)) u_vlan (
    .clk(CLK),
    .rst(SYS_RST),
    .we(vl_we),
    .waddr(vidx_q[VID_W-1:0]),
    .wdata(vl_wword),
    .raddr_a(vidx_q[VID_W-1:0]),
    .rdata_a(vl_rd_a),
    .raddr_b(LKP_VID),
    .rdata_b(vl_rd_b)
  );

  //////////////////////////////////////////////////////////////////////
  // Static entry view for the lookup engine, straight from the read reg

  assign STAT_VALID = st_rd_b[96 + S1_VALID_BIT];
  assign STAT_PORT_STATE_BYPASS = st_rd_b[64 + S2_BYPASS_BIT];
  assign STAT_MULTICAST_GROUP_MATCH_EN = st_rd_b[64 + S2_GRPM_BIT];
  assign STAT_FWD_MASK = st_rd_b[64 +: NPORT];
  assign STAT_FILTER_GROUP_ID = st_rd_b[32 + S3_FGID_LSB +: FGID_W];
  assign STAT_MAC = {st_rd_b[47:32], st_rd_b[31:0]};

  //////////////////////////////////////////////////////////////////////
  // VLAN ingress lookup: request, table read, result

  logic req1_q; // Lookup in flight
  logic [MAC_W-1:0] da1_q; // Address of the frame in flight
  wire [FGID_W-1:0] l_fgid = vl_rd_b[VE_FGID_LSB +: FGID_W];
  wire l_fwdopt = vl_rd_b[VE_FWDOPT_BIT];
  wire [NPORT-1:0] l_memb = vl_rd_b[28:22];

  // Capture request only while VLAN mode is on
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      req1_q <= 1'b0;
      da1_q <= '0;
    end else begin
      req1_q <= LKP_REQ && lk_en;
      da1_q <= LKP_DA;
    end
  end

  // Result registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      LKP_VALID <= 1'b0;
      LKP_ENTRY_VALID <= 1'b0;
      LKP_PRIORITY <= '0;
      LKP_SPANNING_TREE_INSTANCE <= '0;
      LKP_FWD_MASK <= '0;
      LKP_ALT_FWD <= 1'b0;
      LKP_UNTAG_MASK <= '0;
      LKP_HASH_IDX <= '0;
    end else begin
      LKP_VALID <= req1_q;
      LKP_ENTRY_VALID <= vl_rd_b[VE_VALID_BIT];
      LKP_PRIORITY <= vl_rd_b[VE_PRIO_LSB +: 3];
      LKP_SPANNING_TREE_INSTANCE <= vl_rd_b[VE_STI_LSB +: 3];
      // Membership when option set, else all ports for the alt path
      LKP_FWD_MASK <= l_fwdopt ? l_memb : '1;
      LKP_ALT_FWD <= !l_fwdopt;
      LKP_UNTAG_MASK <= vl_rd_b[21:15];
      LKP_HASH_IDX <= fold({l_fgid, da1_q});
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Avalon slave: reads wait one cycle, writes never wait

  wire [31:0] rd_mux =
    AVS_ADDRESS == OFS_SENT1 ? sent1_q :
    AVS_ADDRESS == OFS_SENT2 ? sent2_q :
    AVS_ADDRESS == OFS_SENT3 ? sent3_q :
    AVS_ADDRESS == OFS_SENT4 ? sent4_q :
    AVS_ADDRESS == OFS_TCTL ? tctl_q :
    AVS_ADDRESS == OFS_VENT0 ? vent0_q :
    AVS_ADDRESS == OFS_VENT1 ? vent1_q :
    AVS_ADDRESS == OFS_VENT2 ? vent2_q :
    AVS_ADDRESS == OFS_VIDX ? vidx_q :
    AVS_ADDRESS == OFS_VCTL ? vctl_q :
    AVS_ADDRESS == OFS_LKCTL ? lkctl_q : RST_WORD; // Unmapped reads 0

  assign AVS_WAITREQUEST = rd_take;
  assign AVS_READDATA = rdata_q;

  // Read data register and answer flag
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rd_ack_q <= 1'b0;
      rdata_q <= RST_WORD;
    end else begin
      rd_ack_q <= rd_take;
      if (rd_take) rdata_q <= rd_mux;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks

  go_clear_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    $rose(tc_go) |-> ##[1:3] !tc_go)
    else $error("shared go bit did not clear");

  vgo_clear_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    $rose(vc_go) |-> ##[1:4] !vc_go)
    else $error("VLAN start bit did not clear");

  busy_ignore_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (tc_go && wr_tctl) |=> $stable(tctl_q[TC_SEL_BIT:0]) || !tc_go)
    else $error("control changed while access pending");

  lkp_off_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (LKP_REQ && !lk_en) |-> ##2 !LKP_VALID)
    else $error("lookup answered with VLAN mode off");

  lkp_on_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (LKP_REQ && lk_en) |-> ##2 LKP_VALID)
    else $error("lookup result missing");

  fwd_sel_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    req1_q && l_fwdopt |=> LKP_FWD_MASK == $past(l_memb) && !LKP_ALT_FWD)
    else $error("membership mask not forwarded");

  mc_read_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    cap_mc |=> sent2_q[NPORT-1:0] == $past(mc_rmask) && !tc_go)
    else $error("multicast read result not presented");

  vl_read_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    cap_vl |=> vent0_q[14:0] == $past(vl_rd_a[14:0]) &&
      vent1_q[NPORT-1:0] == $past(vl_rd_a[21:15]) &&
      vent2_q[NPORT-1:0] == $past(vl_rd_a[28:22]))
    else $error("VLAN read result not presented");

  sel_one_a: assert property (
    @(posedge CLK) disable iff (SYS_RST)
    (capt && !kind_q && sel_q == SEL_MCAST && !wr_sent1) |=>
      $stable(sent1_q))
    else $error("multicast access touched static word");

endmodule
`default_nettype wire

/* rtl/swta_pkg.sv */
// Shared constants for the switch table indirect access block.
// Assumes a 32-bit register bus with byte addresses on 12 bits.
package swta_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_VENT0 = 12'h400;
  localparam logic [11:0] OFS_VENT1 = 12'h404;
  localparam logic [11:0] OFS_VENT2 = 12'h408;
  localparam logic [11:0] OFS_VIDX = 12'h40c;
  localparam logic [11:0] OFS_VCTL = 12'h410;
  localparam logic [11:0] OFS_LKCTL = 12'h414;
  localparam logic [11:0] OFS_TCTL = 12'h41c;
  localparam logic [11:0] OFS_SENT1 = 12'h420;
  localparam logic [11:0] OFS_SENT2 = 12'h424;
  localparam logic [11:0] OFS_SENT3 = 12'h428;
  localparam logic [11:0] OFS_SENT4 = 12'h42c;

  // Sizes
  localparam int NPORT = 7;
  localparam int VID_W = 12;
  localparam int STAT_AW = 4;
  localparam int MC_IDX_W = 6;
  localparam int MC_ENTRIES = 48;
  localparam int MC_GROUPS = 8;
  localparam int MAC_W = 48;
  localparam int FGID_W = 7;
  localparam int HIN_W = FGID_W + MAC_W;
  localparam int STAT_W = 128;
  localparam int VENT_W = 29;

  // Shared table control fields
  localparam int TC_ACT_BIT = 6;
  localparam int TC_GO_BIT = 7;
  localparam int TC_SEL_BIT = 8;
  // VLAN access control and lookup control fields
  localparam int VC_ACT_BIT = 0;
  localparam int VC_GO_BIT = 7;
  localparam int LK_EN_BIT = 0;
  // Static entry word fields
  localparam int S2_BYPASS_BIT = 31;
  localparam int S2_GRPM_BIT = 30;
  localparam int S1_VALID_BIT = 31;
  localparam int S3_FGID_LSB = 16;
  // VLAN entry word 0 fields
  localparam int VE_VALID_BIT = 0;
  localparam int VE_FWDOPT_BIT = 1;
  localparam int VE_PRIO_LSB = 2;
  localparam int VE_STI_LSB = 5;
  localparam int VE_FGID_LSB = 8;

  // Writable bit masks, reserved bits read zero
  localparam logic [31:0] SENT1_MASK = 32'hfc00_0007;
  localparam logic [31:0] SENT2_MASK = 32'hc000_007f;
  localparam logic [31:0] SENT3_MASK = 32'h007f_ffff;
  localparam logic [31:0] SENT4_MASK = 32'hffff_ffff;
  localparam logic [31:0] VENT0_MASK = 32'h0000_7fff;
  localparam logic [31:0] PMASK_MASK = 32'h0000_007f;
  localparam logic [31:0] VIDX_MASK = 32'h0000_0fff;
  localparam logic [31:0] TCTL_MASK = 32'h0000_01ff;
  localparam logic [31:0] VCTL_MASK = 32'h0000_0081;
  localparam logic [31:0] LKCTL_MASK = 32'h0000_0001;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Action and table select encodings
  localparam logic ACT_WRITE = 1'b0;
  localparam logic ACT_READ = 1'b1;
  localparam logic SEL_STATIC = 1'b0;
  localparam logic SEL_MCAST = 1'b1;

endpackage

/* rtl/swta_ram.sv */
// Simple table memory with one write port and two registered read ports.
// Assumes contents are written by software before they are looked up.
`timescale 1ns/1ps
`default_nettype none
module swta_ram #(
  parameter int W = 8,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr_a,
  output logic [W-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [W-1:0] rdata_b
);
  // Storage array, no reset
  logic [W-1:0] mem [2**AW];

  // Write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered reads; port a serves software, port b the lookup
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule
`default_nettype wire

/* rtl/swta_mcast.sv */
// Reserved multicast forwarding table: 48 addresses in 8 groups, 3 of them shared.
// Assumes one access per cycle from the indirect access sequencer.
`timescale 1ns/1ps
`default_nettype none
module swta_mcast (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [swta_pkg::MC_IDX_W-1:0] idx,
  input wire logic [swta_pkg::NPORT-1:0] wmask,
  output logic [swta_pkg::NPORT-1:0] rmask_q
);
  import swta_pkg::*;

  // Map address low bits to {hit, group}
  function automatic logic [3:0] grp_of(input logic [MC_IDX_W-1:0] a);
    logic [3:0] r;
    r = 4'h0;
    if (a == 6'h00) r = 4'h8;
    else if (a == 6'h01) r = 4'h9;
    else if (a == 6'h10) r = 4'hb;
    else if (a == 6'h20) r = 4'hc;
    else if (a == 6'h21) r = 4'hd;
    else if (a < 6'h10) r = 4'ha;
    else if (a < 6'h20) r = 4'hf;
    else if (a < 6'(MC_ENTRIES)) r = 4'he;
    return r;
  endfunction

  logic [3:0] map; // Hit flag and group number
  logic hit; // Index names one of the 48 addresses
  logic [2:0] grp; // Group of the index
  logic [NPORT-1:0] grp_mask_q [MC_GROUPS]; // One mask per group

  assign map = grp_of(idx);
  assign hit = map[3];
  assign grp = map[2:0];

  // One mask register per group
  for (genvar g = 0; g < MC_GROUPS; g++) begin : g_grp
    always_ff @(posedge clk) begin
      if (rst) begin
        grp_mask_q[g] <= '0;
      end else if (we && hit && grp == 3'(g)) begin
        grp_mask_q[g] <= wmask;
      end
    end
    grp_write_a: assert property (
      @(posedge clk) disable iff (rst)
      (we && hit && grp == 3'(g)) |=> grp_mask_q[g] == $past(wmask))
      else $error("group mask not taken from write");
    grp_keep_a: assert property (
      @(posedge clk) disable iff (rst)
      (we && !(hit && grp == 3'(g))) |=> $stable(grp_mask_q[g]))
      else $error("group mask changed by foreign index");
  end

  // Registered read; indices past the table read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rmask_q <= '0;
    end else begin
      rmask_q <= hit ? grp_mask_q[grp] : '0;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the switch table indirect access block.
// Drives the Avalon-MM slave and the lookup port itself, no partner.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import swta_pkg::*;
  logic CLK = 1'b0, SYS_RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [11:0] AVS_ADDRESS = 12'h000, LKP_VID = 12'h000, vid;
  logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd, lk, w2, w3, w4;
  logic [31:0] seed = 32'h43, v0, v1, v2;
  logic AVS_WAITREQUEST, LKP_REQ = 1'b0, LKP_VALID, LKP_EV, LKP_ALT;
  logic [47:0] LKP_DA = 48'h0, STAT_MAC;
  logic [2:0] LKP_PRIO, LKP_STI;
  logic [6:0] LKP_FWD, LKP_UNTAG, STAT_FWD, STAT_FGID;
  logic [3:0] STAT_IDX = 4'h0, si;
  logic STAT_BYP, STAT_GRPM, STAT_V, hold = 1'b0;
  logic [11:0] LKP_HASH;
  logic [63:0] exp_q[$], e;
  int err_count = 0, total_checks = 0;
  // Packed lookup result as the monitor sees it
  assign lk = {10'h000, LKP_EV, LKP_PRIO, LKP_STI, LKP_FWD, LKP_ALT, LKP_UNTAG};
  always #4 CLK = ~CLK;
  swta_top i_swta_top (.CLK(CLK), .SYS_RST(SYS_RST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .LKP_REQ(LKP_REQ), .LKP_VID(LKP_VID), .LKP_DA(LKP_DA),
    .LKP_VALID(LKP_VALID), .LKP_ENTRY_VALID(LKP_EV), .LKP_PRIORITY(LKP_PRIO),
    .LKP_SPANNING_TREE_INSTANCE(LKP_STI), .LKP_FWD_MASK(LKP_FWD),
    .LKP_ALT_FWD(LKP_ALT), .LKP_UNTAG_MASK(LKP_UNTAG),
    .LKP_HASH_IDX(LKP_HASH), .STAT_IDX(STAT_IDX), .STAT_VALID(STAT_V),
    .STAT_PORT_STATE_BYPASS(STAT_BYP),
    .STAT_MULTICAST_GROUP_MATCH_EN(STAT_GRPM), .STAT_FWD_MASK(STAT_FWD),
    .STAT_FILTER_GROUP_ID(STAT_FGID), .STAT_MAC(STAT_MAC));
  ////////////////////////////////////////////////////////////////////////
  // Next random value, seeded at 67
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Reference fold of group id and address into a 12-bit index
  function logic [11:0] hfold(input logic [54:0] v);
    hfold = 12'h0;
    for (int i = 0; i < 55; i++) hfold[i % 12] ^= v[i];
  endfunction
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One bus cycle, held until waitrequest is low at a rising edge;
  // called just after a rising edge; hold keeps the strobe for the next
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    AVS_ADDRESS <= a;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    AVS_WRITEDATA <= d;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
    if (AVS_WAITREQUEST !== 1'b0) begin
      err_count++;
      end_of_test;
    end
    rd = AVS_READDATA;
    if (!hold) begin
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      @(posedge CLK);
    end
  endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] x);
    exp_q.push_back({32'hffffffff, x});
    bus(1'b0, a, 32'h0);
  endtask
  // Poll a go bit until it clears, bounded
  task poll(input logic [11:0] a);
    int n;
    for (n = 0; n < 20; n++) begin
      exp_q.push_back(64'h0);
      bus(1'b0, a, 32'h0);
      if (rd[7] === 1'b0) break;
    end
    if (n == 20) begin
      check(32'h1, 32'h0);
      end_of_test;
    end
  endtask
  // Monitor: oldest note against each result that appears
  always @(negedge CLK) begin
    if (!SYS_RST && ((AVS_READ && AVS_WAITREQUEST === 1'b0) ||
        LKP_VALID === 1'b1)) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 64'hffffffff_00000bad;
      check((AVS_READ ? AVS_READDATA : lk) & e[63:32], e[31:0]);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    rd_chk(12'h418, 32'h0);
    // Static entry write, clear, read back
    seed = lfsr(seed); w2 = seed; seed = lfsr(seed); w3 = seed;
    seed = lfsr(seed); w4 = seed; si = seed[7:4];
    bus(1'b1, OFS_SENT1, 32'hffffffff);
    bus(1'b1, OFS_SENT2, w2); bus(1'b1, OFS_SENT3, w3);
    bus(1'b1, OFS_SENT4, w4);
    // Go write, then a second control write at once while go is pending
    hold = 1'b1;
    bus(1'b1, OFS_TCTL, {24'h0, 4'h8, si});
    hold = 1'b0;
    bus(1'b1, OFS_TCTL, 32'h1ff);
    poll(OFS_TCTL);
    rd_chk(OFS_TCTL, {28'h0, si});
    bus(1'b1, OFS_SENT1, 32'h0);
    bus(1'b1, OFS_SENT2, 32'h0); bus(1'b1, OFS_SENT3, 32'h0);
    bus(1'b1, OFS_SENT4, 32'h0);
    bus(1'b1, OFS_TCTL, {24'h0, 4'hc, si});
    poll(OFS_TCTL);
    rd_chk(OFS_SENT2, w2 & SENT2_MASK);
    rd_chk(OFS_SENT3, w3 & SENT3_MASK);
    rd_chk(OFS_SENT4, w4);
    rd_chk(OFS_SENT1, SENT1_MASK);
    STAT_IDX <= si;
    @(posedge CLK);
    @(negedge CLK);
    check({STAT_BYP, STAT_GRPM, 15'h0, STAT_V, STAT_FGID, STAT_FWD},
      {w2[31:30], 15'h0, 1'b1, w3[22:16], w2[6:0]});
    check(STAT_MAC[47:16], {w3[15:0], w4[31:16]});
    check(STAT_MAC[31:0], w4);
    @(posedge CLK);
    // Multicast: write index 0x02, read 0x0f of the same group
    seed = lfsr(seed);
    bus(1'b1, OFS_SENT2, {25'h0, seed[6:0]});
    bus(1'b1, OFS_TCTL, 32'h182);
    poll(OFS_TCTL);
    bus(1'b1, OFS_SENT2, 32'h0);
    bus(1'b1, OFS_TCTL, 32'h1cf);
    poll(OFS_TCTL);
    rd_chk(OFS_SENT2, {25'h0, seed[6:0]});
    // VLAN entry write, lookup, read back
    seed = lfsr(seed); v0 = (seed & VENT0_MASK) | 32'h2; vid = seed[27:16];
    seed = lfsr(seed); v1 = seed & PMASK_MASK; v2 = seed[31:8] & PMASK_MASK;
    bus(1'b1, OFS_VENT0, v0); bus(1'b1, OFS_VENT1, v1);
    bus(1'b1, OFS_VENT2, v2); bus(1'b1, OFS_VIDX, {20'h0, vid});
    bus(1'b1, OFS_VCTL, 32'h80);
    poll(OFS_VCTL);
    // Same entry with forward option 0 at the neighbouring VID
    bus(1'b1, OFS_VENT0, v0 ^ 32'h2);
    bus(1'b1, OFS_VIDX, {20'h0, vid ^ 12'h001});
    bus(1'b1, OFS_VCTL, 32'h80);
    poll(OFS_VCTL);
    // Request while VLAN mode is off must get no answer
    LKP_REQ <= 1'b1;
    @(posedge CLK);
    LKP_REQ <= 1'b0;
    bus(1'b1, OFS_LKCTL, 32'h1);
    exp_q.push_back({32'hffffffff, 10'h0, v0[0], v0[4:2], v0[7:5], v2[6:0],
      1'b0, v1[6:0]});
    exp_q.push_back({32'hffffffff, 10'h0, v0[0], v0[4:2], v0[7:5], 7'h7f,
      1'b1, v1[6:0]});
    LKP_REQ <= 1'b1; LKP_VID <= vid; LKP_DA <= {seed, seed[15:0]};
    @(posedge CLK);
    LKP_VID <= vid ^ 12'h001;
    @(posedge CLK);
    LKP_REQ <= 1'b0;
    @(negedge CLK);
    check({20'h0, LKP_HASH}, {20'h0, hfold({v0[14:8], LKP_DA})});
    repeat (4) @(posedge CLK);
    bus(1'b1, OFS_VIDX, {20'h0, vid});
    bus(1'b1, OFS_VENT0, 32'h0); bus(1'b1, OFS_VENT1, 32'h0);
    bus(1'b1, OFS_VENT2, 32'h0); bus(1'b1, OFS_VCTL, 32'h81);
    poll(OFS_VCTL);
    rd_chk(OFS_VENT0, v0);
    rd_chk(OFS_VENT1, v1);
    rd_chk(OFS_VENT2, v2);
    check(32'(exp_q.size()), 32'h0);
    end_of_test;
  end
endmodule
`default_nettype wire
